//--- hw/dlrx_irq_top.v
`timescale 1ns/1ps
`default_nettype none
`include "dlrx_defs.vh"
module dlrx_irq_top (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // register port
  input wire [`DLRX_ADDR_W-1:0] regAddr,
  input wire regWrEn,
  input wire [31:0] regWrData,
  input wire regRdEn,
  output reg [31:0] regRdData_r,
  output reg regRdValid_r,
  // receiver A datapath events (asynchronous)
  input wire [`DLRX_IN_W-1:0] rxAEvents,
  // receiver B datapath events (asynchronous)
  input wire [`DLRX_IN_W-1:0] rxBEvents,
  // combined interrupts toward the south display status
  output reg rxAIrq_r,
  output reg rxBIrq_r
);
  wire [2*`DLRX_IN_W-1:0] evSync;
  wire [`DLRX_IN_W-1:0] evA;
  wire [`DLRX_IN_W-1:0] evB;

  reg [`DLRX_NBITS-1:0] maskA_r;
  reg [`DLRX_NBITS-1:0] maskB_r;
  reg [`DLRX_NBITS-1:0] statA_r;
  reg [`DLRX_NBITS-1:0] statB_r;
  reg [`DLRX_NBITS-1:0] statA_nxt;
  reg [`DLRX_NBITS-1:0] statB_nxt;

  reg [7:0] bitCntA_r;
  reg [7:0] bitCntB_r;
  reg [3:0] symCntA_r;
  reg [3:0] symCntB_r;
  reg tp2PrevA_r;
  reg tp2PrevB_r;
  reg bitLockA_r;
  reg bitLockB_r;
  reg symLockA_r;
  reg symLockB_r;

  // next values, kept apart from the flops
  reg [7:0] bitCntA_nxt;
  reg [7:0] bitCntB_nxt;
  reg [3:0] symCntA_nxt;
  reg [3:0] symCntB_nxt;
  reg tp2PrevA_nxt;
  reg tp2PrevB_nxt;
  reg bitLockA_nxt;
  reg bitLockB_nxt;
  reg symLockA_nxt;
  reg symLockB_nxt;
  reg [`DLRX_NBITS-1:0] maskA_nxt;
  reg [`DLRX_NBITS-1:0] maskB_nxt;
  reg rxAIrq_nxt;
  reg rxBIrq_nxt;
  reg regRdValid_nxt;
  reg [31:0] regRdData_nxt;

  // register port decode
  wire wrMaskA;
  wire wrMaskB;

  dlrx_sync2 #(.WIDTH(2*`DLRX_IN_W)) uSync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .asyncIn({rxBEvents, rxAEvents}),
    .syncOut(evSync)
  );

  assign evA = evSync[`DLRX_IN_W-1:0];
  assign evB = evSync[2*`DLRX_IN_W-1:`DLRX_IN_W];
  assign wrMaskA = regWrEn && regHit(regAddr, `DLRX_RX_A_IRQ_MASK);
  assign wrMaskB = regWrEn && regHit(regAddr, `DLRX_RX_B_IRQ_MASK);

  // consecutive good-character cycles; any break or retrain starts over
  function [7:0] bitCntStep;
    input [7:0] cnt;
    input [`DLRX_IN_W-1:0] ev;
    begin
      if (ev[`DLRX_IN_RETRAIN] || !ev[`DLRX_IN_TP1OK])
        bitCntStep = 8'h00;
      else if (cnt != `DLRX_BIT_LOCK_CYCLES)
        bitCntStep = cnt + 8'h01;
      else
        bitCntStep = cnt;
    end
  endfunction

  // consecutive completed second patterns; a failure starts over
  function [3:0] symCntStep;
    input [3:0] cnt;
    input [`DLRX_IN_W-1:0] ev;
    input prevOk;
    begin
      if (ev[`DLRX_IN_RETRAIN] || ev[`DLRX_IN_TP2FAIL])
        symCntStep = 4'h0;
      else if (ev[`DLRX_IN_TP2OK] && !prevOk && cnt != `DLRX_SYM_LOCK_PATTERNS)
        symCntStep = cnt + 4'h1;
      else
        symCntStep = cnt;
    end
  endfunction

  // lock holds until the receiver is retrained
  function lockStep;
    input lockNow;
    input reached;
    input [`DLRX_IN_W-1:0] ev;
    begin
      if (ev[`DLRX_IN_RETRAIN])
        lockStep = 1'b0;
      else
        lockStep = lockNow | reached;
    end
  endfunction

  function [`DLRX_NBITS-1:0] buildStatus;
    input [`DLRX_IN_W-1:0] ev;
    input bitLock;
    input symLock;
    reg [`DLRX_NBITS-1:0] s;
    begin
      s = `DLRX_STATUS_RESET;
      s[`DLRX_BIT_PIX_OVF] = ev[`DLRX_IN_PIX];
      s[`DLRX_BIT_XCLK_OVF] = ev[`DLRX_IN_XCLK];
      s[`DLRX_BIT_SYMQ_OVF] = ev[`DLRX_IN_SYMQ];
      s[`DLRX_BIT_ALIGN] = ev[`DLRX_IN_ALIGN];
      s[`DLRX_BIT_SYM_LOCK] = symLock;
      s[`DLRX_BIT_BIT_LOCK] = bitLock;
      s[`DLRX_BIT_TP2_FAIL] = ev[`DLRX_IN_TP2FAIL];
      s[`DLRX_BIT_DRIFT] = ev[`DLRX_IN_DRIFT];
      s[`DLRX_BIT_ERR_RATE] = ev[`DLRX_IN_ERR];
      buildStatus = s & `DLRX_RSVD_KEEP;
    end
  endfunction

  function irqOf;
    input [`DLRX_NBITS-1:0] stat;
    input [`DLRX_NBITS-1:0] mask;
    begin
      irqOf = |(stat & ~mask);
    end
  endfunction

  // one address compare, shared by both mask write decodes
  function regHit;
    input [`DLRX_ADDR_W-1:0] addr;
    input [`DLRX_ADDR_W-1:0] target;
    begin
      regHit = (addr == target);
    end
  endfunction

  // only the eleven mask bits are stored; upper write bits are dropped
  function [`DLRX_NBITS-1:0] maskStep;
    input [`DLRX_NBITS-1:0] maskNow;
    input wrHit;
    input [31:0] wrData;
    begin
      if (wrHit)
        maskStep = wrData[`DLRX_NBITS-1:0];
      else
        maskStep = maskNow;
    end
  endfunction

  // bits 31:11 of a returned word are always zero
  function [31:0] padWord;
    input [`DLRX_NBITS-1:0] val;
    begin
      padWord = {{(32-`DLRX_NBITS){1'b0}}, val};
    end
  endfunction

  // status writes land nowhere, unmapped reads return zero
  function [31:0] readWord;
    input [`DLRX_ADDR_W-1:0] addr;
    input [`DLRX_NBITS-1:0] sA;
    input [`DLRX_NBITS-1:0] mA;
    input [`DLRX_NBITS-1:0] sB;
    input [`DLRX_NBITS-1:0] mB;
    begin
      case (addr)
        `DLRX_RX_A_IRQ_STATUS: readWord = padWord(sA);
        `DLRX_RX_A_IRQ_MASK: readWord = padWord(mA);
        `DLRX_RX_B_IRQ_STATUS: readWord = padWord(sB);
        `DLRX_RX_B_IRQ_MASK: readWord = padWord(mB);
        default: readWord = 32'h0000_0000;
      endcase
    end
  endfunction

  // status follows the synchronised levels and the lock flops
  always @* begin
    statA_nxt = buildStatus(evA, bitLockA_r, symLockA_r);
    statB_nxt = buildStatus(evB, bitLockB_r, symLockB_r);
  end

  // lock qualification, both receivers
  always @* begin
    bitCntA_nxt = bitCntStep(bitCntA_r, evA);
    bitCntB_nxt = bitCntStep(bitCntB_r, evB);
    symCntA_nxt = symCntStep(symCntA_r, evA, tp2PrevA_r);
    symCntB_nxt = symCntStep(symCntB_r, evB, tp2PrevB_r);
    tp2PrevA_nxt = evA[`DLRX_IN_TP2OK];
    tp2PrevB_nxt = evB[`DLRX_IN_TP2OK];
    bitLockA_nxt = lockStep(bitLockA_r, bitCntA_r == `DLRX_BIT_LOCK_CYCLES, evA);
    bitLockB_nxt = lockStep(bitLockB_r, bitCntB_r == `DLRX_BIT_LOCK_CYCLES, evB);
    // symbol lock also needs bit lock first
    symLockA_nxt = lockStep(symLockA_r,
      bitLockA_r && symCntA_r == `DLRX_SYM_LOCK_PATTERNS, evA);
    symLockB_nxt = lockStep(symLockB_r,
      bitLockB_r && symCntB_r == `DLRX_SYM_LOCK_PATTERNS, evB);
  end

  // register port and combined interrupts
  always @* begin
    maskA_nxt = maskStep(maskA_r, wrMaskA, regWrData);
    maskB_nxt = maskStep(maskB_r, wrMaskB, regWrData);
    rxAIrq_nxt = irqOf(statA_r, maskA_r);
    rxBIrq_nxt = irqOf(statB_r, maskB_r);
    regRdValid_nxt = regRdEn;
    regRdData_nxt = 32'h0000_0000;
    if (regRdEn)
      regRdData_nxt = readWord(regAddr, statA_r, maskA_r, statB_r, maskB_r);
  end

  // receiver A lock qualifiers
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitCntA_r <= 8'h00;
      symCntA_r <= 4'h0;
      tp2PrevA_r <= 1'b0;
      bitLockA_r <= 1'b0;
      symLockA_r <= 1'b0;
    end else begin
      bitCntA_r <= bitCntA_nxt;
      symCntA_r <= symCntA_nxt;
      tp2PrevA_r <= tp2PrevA_nxt;
      bitLockA_r <= bitLockA_nxt;
      symLockA_r <= symLockA_nxt;
    end
  end

  // receiver B lock qualifiers
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitCntB_r <= 8'h00;
      symCntB_r <= 4'h0;
      tp2PrevB_r <= 1'b0;
      bitLockB_r <= 1'b0;
      symLockB_r <= 1'b0;
    end else begin
      bitCntB_r <= bitCntB_nxt;
      symCntB_r <= symCntB_nxt;
      tp2PrevB_r <= tp2PrevB_nxt;
      bitLockB_r <= bitLockB_nxt;
      symLockB_r <= symLockB_nxt;
    end
  end

  // receiver A status and mask
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      statA_r <= `DLRX_STATUS_RESET;
      maskA_r <= `DLRX_MASK_RESET;
    end else begin
      statA_r <= statA_nxt;
      maskA_r <= maskA_nxt;
    end
  end

  // receiver B status and mask
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      statB_r <= `DLRX_STATUS_RESET;
      maskB_r <= `DLRX_MASK_RESET;
    end else begin
      statB_r <= statB_nxt;
      maskB_r <= maskB_nxt;
    end
  end

  // combined interrupts, one cycle behind status and mask
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxAIrq_r <= 1'b0;
      rxBIrq_r <= 1'b0;
    end else begin
      rxAIrq_r <= rxAIrq_nxt;
      rxBIrq_r <= rxBIrq_nxt;
    end
  end

  // read answer stands for one cycle only
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData_r <= 32'h0000_0000;
      regRdValid_r <= 1'b0;
    end else begin
      regRdData_r <= regRdData_nxt;
      regRdValid_r <= regRdValid_nxt;
    end
  end
endmodule // dlrx_irq_top
`default_nettype wire

//--- common/dlrx_defs.vh
// Contract
// - status bit 2 reads 1 when the pixel FIFO overflowed, else 0.
// - status bit 1 reads 1 when the symbol-to-display clock FIFO overflowed.
// - eleven-bit software-writable mask, one bit per status bit.
// - mask 0 lets a status bit reach the combined interrupt; 1 blocks it.
// - mask resets to all eleven bits set.
// - second receiver has read-only status at its own offset, reset zero, same layout.
// - alignment bit reads 1 when all enabled lanes are aligned.
// - symbol lock bit reads 1 once symbol lock is achieved.
// - bit lock bit reads 1 once bit lock is achieved.
// - second training fail bit reads 1 when that phase failed.
// - drift bit reads 1 when recovered clock drifted from data.
// - error-rate bit reads 1 when symbol error rate exceeds threshold.
// - symbol lock only after consecutive good second patterns on all lanes.
// - bit lock only after consecutive good first-pattern characters on all lanes.
`ifndef DLRX_DEFS_VH
`define DLRX_DEFS_VH

`define DLRX_ADDR_W 20
`define DLRX_RX_A_IRQ_STATUS 20'hF_0014
`define DLRX_RX_A_IRQ_MASK 20'hF_0018
`define DLRX_RX_B_IRQ_STATUS 20'hF_1014
`define DLRX_RX_B_IRQ_MASK 20'hF_1018

`define DLRX_NBITS 11
`define DLRX_MASK_RESET 11'h7FF
`define DLRX_STATUS_RESET 11'h000
`define DLRX_RSVD_KEEP 11'h7B7

`define DLRX_BIT_SYMQ_OVF 0
`define DLRX_BIT_XCLK_OVF 1
`define DLRX_BIT_PIX_OVF 2
`define DLRX_BIT_ERR_RATE 4
`define DLRX_BIT_DRIFT 5
`define DLRX_BIT_TP2_FAIL 7
`define DLRX_BIT_BIT_LOCK 8
`define DLRX_BIT_SYM_LOCK 9
`define DLRX_BIT_ALIGN 10

// raw input vector per receiver
`define DLRX_IN_W 10
`define DLRX_IN_PIX 0
`define DLRX_IN_XCLK 1
`define DLRX_IN_SYMQ 2
`define DLRX_IN_ALIGN 3
`define DLRX_IN_DRIFT 4
`define DLRX_IN_ERR 5
`define DLRX_IN_TP1OK 6
`define DLRX_IN_TP2OK 7
`define DLRX_IN_TP2FAIL 8
`define DLRX_IN_RETRAIN 9

`define DLRX_BIT_LOCK_CYCLES 8'd16
`define DLRX_SYM_LOCK_PATTERNS 4'd4

`endif

//--- hw/dlrx_sync2.v
`timescale 1ns/1ps
`default_nettype none
module dlrx_sync2 #(
  parameter WIDTH = 20
) (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // data
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // first stage is read by the second stage only
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= asyncIn;
      sync_r <= meta_r;
    end
  end

  assign syncOut = sync_r;
endmodule // dlrx_sync2
`default_nettype wire

//--- testbench/dlrx_irq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "dlrx_defs.vh"
module dlrx_irq_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [19:0] regAddr,
  input wire logic regWrEn,
  input wire logic [31:0] regWrData,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData_r,
  input wire logic regRdValid_r,
  // receiver A
  input wire logic [9:0] rxAEvents,
  input wire logic rxAIrq_r
);
  logic [9:0] prev_r;
  logic [2:0] held_r;
  logic [10:0] mask_r;
  wire stRd = regRdEn && regAddr == `DLRX_RX_A_IRQ_STATUS;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // held_r counts still cycles so that the sync latency is known to be over
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= 10'h000;
      held_r <= 3'h0;
      mask_r <= `DLRX_MASK_RESET;
    end else begin
      prev_r <= rxAEvents;
      held_r <= (rxAEvents != prev_r) ? 3'h0 : held_r + {2'h0, held_r != 3'h7};
      if (regWrEn && regAddr == `DLRX_RX_A_IRQ_MASK)
        mask_r <= regWrData[10:0];
    end
  end
  rd_answer_a: assert property (regRdValid_r == $past(regRdEn))
    else $error("read answer");
  rsvd_zero_a: assert property (regRdValid_r |-> regRdData_r[31:11] == 21'h0)
    else $error("reserved bits");
  ovf_bits_a: assert property (stRd && held_r > 3'h3 |=>
    regRdData_r[2:0] == {$past(prev_r[0]), $past(prev_r[1]), $past(prev_r[2])})
    else $error("overflow bits");
  lvl_bits_a: assert property (stRd && held_r > 3'h3 |=>
    {regRdData_r[10], regRdData_r[5:3]} ==
    {$past(prev_r[3]), $past(prev_r[4]), $past(prev_r[5]), 1'b0})
    else $error("level bits");
  retrain_lock_a: assert property (stRd && held_r > 3'h3 && prev_r[9] |=>
    regRdData_r[9:8] == 2'b00) else $error("lock in retrain");
  sym_lock_a: assert property (stRd |=> !regRdData_r[9] || regRdData_r[8])
    else $error("symbol lock");
  mask_all_a: assert property (mask_r == 11'h7FF && $past(mask_r) == 11'h7FF |->
    !rxAIrq_r) else $error("masked irq");
  irq_on_a: assert property (held_r > 3'h5 && prev_r[0] && !mask_r[2] &&
    $stable(mask_r) && mask_r == $past(mask_r, 2) |-> rxAIrq_r) else $error("irq missed");
endmodule // dlrx_irq_monitor
bind dlrx_irq_top dlrx_irq_monitor mon (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
  .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
  .regRdValid_r(regRdValid_r), .rxAEvents(rxAEvents), .rxAIrq_r(rxAIrq_r));
`default_nettype wire

//--- testbench/display_link_rx_irq_status_mask_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dlrx_defs.vh"
module display_link_rx_irq_status_mask_tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [19:0] regAddr = 20'h0_0000;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [31:0] regWrData = 32'h0000_0000;
  logic [9:0] evA = 10'h000;
  logic [9:0] evB = 10'h000;
  logic [31:0] rdData, d, sa, sb;
  logic [31:0] expQ[$];
  logic rdValid, irqA, irqB;
  logic [31:0] seed = 32'h0000_0030;
  int errCount = 0;
  int checked = 0;
  dlrx_irq_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_r(rdData), .regRdValid_r(rdValid),
    .rxAEvents(evA), .rxBEvents(evB), .rxAIrq_r(irqA), .rxBIrq_r(irqB));
  initial forever #2 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // lk is {symbol lock, bit lock}
  function automatic logic [31:0] stat(input logic [9:0] e, input logic [1:0] lk);
    return {21'h0, e[3], lk, e[8], 1'b0, e[4], e[5], 1'b0, e[0], e[1], e[2]};
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one strobe cycle; a read compares its answer with v
  task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= w;
    regRdEn <= !w;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    #1;
    if (!w) chk("register", rdData, v);
  endtask
  task automatic endSim;
    $display("checks %0d errors %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    errCount++;
    endSim;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    acc(0, `DLRX_RX_B_IRQ_MASK, 32'h0000_07FF);
    acc(1, `DLRX_RX_A_IRQ_MASK, 32'hFFFF_FFFF);
    acc(0, `DLRX_RX_A_IRQ_MASK, 32'h0000_07FF);
    acc(1, `DLRX_RX_B_IRQ_STATUS, 32'hFFFF_FFFF);
    acc(0, `DLRX_RX_B_IRQ_STATUS, 32'h0000_0000);
    acc(0, 20'hF_0020, 32'h0000_0000);
    for (int i = 0; i < 24; i++) begin
      d = rnd();
      @(posedge ref_clk);
      evA <= d[9:0] & 10'h13F;
      evB <= d[19:10] & 10'h13F;
      expQ.push_back(stat(d[9:0] & 10'h13F, 2'b00));
      expQ.push_back(stat(d[19:10] & 10'h13F, 2'b00));
      d = rnd();
      acc(1, `DLRX_RX_A_IRQ_MASK, {21'h0, d[10:0]});
      acc(1, `DLRX_RX_B_IRQ_MASK, {21'h0, d[21:11]});
      repeat (8) @(posedge ref_clk);
      sa = expQ.pop_front();
      sb = expQ.pop_front();
      acc(0, `DLRX_RX_A_IRQ_STATUS, sa);
      acc(0, `DLRX_RX_B_IRQ_STATUS, sb);
      chk("irqA", {31'h0, irqA}, {31'h0, |(sa & {21'h0, ~d[10:0]})});
      chk("irqB", {31'h0, irqB}, {31'h0, |(sb & {21'h0, ~d[21:11]})});
    end
    acc(1, `DLRX_RX_A_IRQ_MASK, 32'h0000_07FF);
    @(posedge ref_clk);
    evA <= 10'h040;
    repeat (10) @(posedge ref_clk);
    acc(0, `DLRX_RX_A_IRQ_STATUS, 32'h0000_0000);
    repeat (20) @(posedge ref_clk);
    for (int p = 0; p < 4; p++) begin
      acc(0, `DLRX_RX_A_IRQ_STATUS, 32'h0000_0100);
      @(posedge ref_clk);
      evA <= 10'h0C0;
      repeat (3) @(posedge ref_clk);
      evA <= 10'h040;
      repeat (3) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    acc(0, `DLRX_RX_A_IRQ_STATUS, 32'h0000_0300);
    chk("irqA masked", {31'h0, irqA}, 32'h0000_0000);
    @(posedge ref_clk);
    evA <= 10'h200;
    repeat (8) @(posedge ref_clk);
    acc(0, `DLRX_RX_A_IRQ_STATUS, 32'h0000_0000);
    endSim;
  end
endmodule // display_link_rx_irq_status_mask_tb_top
`default_nettype wire
